// File: rtl/ibc_regs_top.sv
`default_nettype none


////////////////////////////////////////////////////////////////////////////////
// Register bank for interrupt mask and latches, bias selection and channel one.
module ibc_regs_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso_out,
  output logic spi_miso_oe,
  input wire logic audio_clk_err_evt,
  input wire logic pll_lock_evt,
  output logic irq_pin_out,
  output logic mic_bias_from_vref,
  output logic mic_bias_from_supply,
  output logic [1:0] vref_select,
  output logic vref_valid,
  output logic chan_one_enable,
  output logic chan_one_mute,
  output logic signed [8:0] chan_one_gain_half_db,
  output logic [3:0] chan_one_gain_trim_code
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage.
  // Page select; only page zero reaches this bank.
  logic [7:0] page_ff;
  // Interrupt polarity, event mode and latch readback filter.
  logic [7:0] int_cfg_ff;
  // Interrupt mask; a one blocks the source.
  logic [7:0] event_mask_reg_ff;
  // Raw latched events: index 1 is the clock error, index 0 the lock event.
  logic [1:0] latched_ff;
  // Bias and reference selection.
  logic [7:0] bias_reference_config_ff;
  // Channel-one source selection.
  logic [7:0] chan_one_source_config_ff;
  // Channel-one volume code.
  logic [7:0] chan_one_volume_ff;
  // Channel-one gain trim.
  logic [7:0] chan_one_gain_trim_ff;

  // Registered decoded outputs.
  logic irq_pin_ff;
  logic bias_vref_ff, bias_supply_ff;
  logic [1:0] vref_sel_ff;
  logic vref_valid_ff;
  logic chan_en_ff;

  // Register access strobes from the control port.
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd;
  logic on_page;
  logic wr_hit_page, wr_hit_cfg, wr_hit_mask, wr_hit_bias, wr_hit_src, wr_hit_vol, wr_hit_trim;

  // Interrupt datapath.
  logic [1:0] evt_now;
  logic [1:0] unmask;
  logic [1:0] shown;
  logic [1:0] clr_bits;
  logic [1:0] nxt_latched;
  logic irq_active;
  logic nxt_irq_pin;

  ////////////////////////////////////////////////////////////////////////////////
  // Control port target.
  ibc_spi_target u_spi (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi),
    .spi_miso_out(spi_miso_out),
    .spi_miso_oe(spi_miso_oe),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode. The page register is reachable on every page.
  assign on_page = (page_ff == ibc_pkg::PAGE_ZERO);
  assign wr_hit_page = reg_wr & (reg_addr == ibc_pkg::ADDR_PAGE);
  assign wr_hit_cfg = reg_wr & on_page & (reg_addr == ibc_pkg::ADDR_INT_CFG);
  assign wr_hit_mask = reg_wr & on_page & (reg_addr == ibc_pkg::ADDR_EVENT_MASK);
  assign wr_hit_bias = reg_wr & on_page & (reg_addr == ibc_pkg::ADDR_BIAS);
  assign wr_hit_src = reg_wr & on_page & (reg_addr == ibc_pkg::ADDR_CH1_SRC);
  assign wr_hit_vol = reg_wr & on_page & (reg_addr == ibc_pkg::ADDR_CH1_VOL);
  assign wr_hit_trim = reg_wr & on_page & (reg_addr == ibc_pkg::ADDR_CH1_TRIM);

  ////////////////////////////////////////////////////////////////////////////////
  // Page select register.
  always_ff @(posedge clk) begin
    if (rst) begin
      page_ff <= ibc_pkg::RST_PAGE;
    end else if (ce && wr_hit_page) begin
      page_ff <= ibc_pkg::ibc_masked_write(reg_wdata, ibc_pkg::WMASK_ALL);
    end
  end

  // Interrupt configuration register.
  always_ff @(posedge clk) begin
    if (rst) begin
      int_cfg_ff <= ibc_pkg::RST_INT_CFG;
    end else if (ce && wr_hit_cfg) begin
      int_cfg_ff <= ibc_pkg::ibc_masked_write(reg_wdata, ibc_pkg::WMASK_INT_CFG);
    end
  end

  // Interrupt mask register; every bit, reserved ones too, resets to one.
  always_ff @(posedge clk) begin
    if (rst) begin
      event_mask_reg_ff <= ibc_pkg::RST_EVENT_MASK;
    end else if (ce && wr_hit_mask) begin
      event_mask_reg_ff <= ibc_pkg::ibc_masked_write(reg_wdata, ibc_pkg::WMASK_ALL);
    end
  end

  // Bias and reference configuration register.
  always_ff @(posedge clk) begin
    if (rst) begin
      bias_reference_config_ff <= ibc_pkg::RST_BIAS;
    end else if (ce && wr_hit_bias) begin
      bias_reference_config_ff <= ibc_pkg::ibc_masked_write(reg_wdata, ibc_pkg::WMASK_BIAS);
    end
  end

  // Channel-one source register; the channel starts disabled.
  always_ff @(posedge clk) begin
    if (rst) begin
      chan_one_source_config_ff <= ibc_pkg::RST_CH1_SRC;
    end else if (ce && wr_hit_src) begin
      chan_one_source_config_ff <= ibc_pkg::ibc_masked_write(reg_wdata, ibc_pkg::WMASK_CH1_SRC);
    end
  end

  // Channel-one volume register; starts at unity gain.
  always_ff @(posedge clk) begin
    if (rst) begin
      chan_one_volume_ff <= ibc_pkg::RST_CH1_VOL;
    end else if (ce && wr_hit_vol) begin
      chan_one_volume_ff <= ibc_pkg::ibc_masked_write(reg_wdata, ibc_pkg::WMASK_ALL);
    end
  end

  // Channel-one gain trim register; low nibble reads zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      chan_one_gain_trim_ff <= ibc_pkg::RST_CH1_TRIM;
    end else if (ce && wr_hit_trim) begin
      chan_one_gain_trim_ff <= ibc_pkg::ibc_masked_write(reg_wdata, ibc_pkg::WMASK_CH1_TRIM);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt latches.
  // Source events, ordered clock error then lock event.
  assign evt_now = {audio_clk_err_evt, pll_lock_evt};
  // A mask bit of zero lets its source through.
  assign unmask[1] = ~event_mask_reg_ff[ibc_pkg::BIT_CLK_ERR];
  assign unmask[0] = ~event_mask_reg_ff[ibc_pkg::BIT_PLL_LOCK];
  // With the filter set, masked latches stay hidden from readback.
  assign shown = int_cfg_ff[ibc_pkg::BIT_LTCH_FILTER] ? (latched_ff & unmask) : latched_ff;
  // A read of the latched register clears exactly the bits it returned.
  assign clr_bits = (reg_rd && on_page && (reg_addr == ibc_pkg::ADDR_LATCHED)) ? shown : 2'h0;
  // The set term is applied after the clear so a coinciding event survives.
  assign nxt_latched = (latched_ff & ~clr_bits) | evt_now;

  // Latch register update.
  always_ff @(posedge clk) begin
    if (rst) begin
      latched_ff <= ibc_pkg::RST_LATCHED;
    end else if (ce) begin
      latched_ff <= nxt_latched;
    end
  end

  // Pending unmasked latch drives the level-mode interrupt.
  assign irq_active = |(latched_ff & unmask);
  // Polarity bit chooses low- or high-active pin.
  assign nxt_irq_pin = int_cfg_ff[ibc_pkg::BIT_IRQ_POL] ? irq_active : ~irq_active;

  // Interrupt pin register; idles high under the low-active reset polarity.
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_pin_ff <= 1'b1;
    end else if (ce) begin
      irq_pin_ff <= nxt_irq_pin;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data mux; unmapped addresses read zero, and on other pages everything but the page register reads zero.
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_addr == ibc_pkg::ADDR_PAGE) begin
      reg_rdata = page_ff;
    end else if (on_page) begin
      case (reg_addr)
        ibc_pkg::ADDR_INT_CFG: begin
          reg_rdata = int_cfg_ff;
        end
        ibc_pkg::ADDR_EVENT_MASK: begin
          reg_rdata = event_mask_reg_ff;
        end
        ibc_pkg::ADDR_LATCHED: begin
          reg_rdata = {shown, {ibc_pkg::LATCHED_PAD{1'b0}}};
        end
        ibc_pkg::ADDR_BIAS: begin
          reg_rdata = bias_reference_config_ff;
        end
        ibc_pkg::ADDR_CH1_SRC: begin
          reg_rdata = chan_one_source_config_ff;
        end
        ibc_pkg::ADDR_CH1_VOL: begin
          reg_rdata = chan_one_volume_ff;
        end
        ibc_pkg::ADDR_CH1_TRIM: begin
          reg_rdata = chan_one_gain_trim_ff;
        end
        default: begin
          reg_rdata = 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bias and reference decode. Reserved codes select neither bias source and
  // flag the reference as invalid, so analog control stays in a safe state.
  always_ff @(posedge clk) begin
    if (rst) begin
      bias_vref_ff <= 1'b1;
      bias_supply_ff <= 1'b0;
      vref_sel_ff <= ibc_pkg::VREF_2V75;
      vref_valid_ff <= 1'b1;
    end else if (ce) begin
      bias_vref_ff <= (bias_reference_config_ff[ibc_pkg::MBIAS_LSB +: 3] == ibc_pkg::MBIAS_VREF);
      bias_supply_ff <= (bias_reference_config_ff[ibc_pkg::MBIAS_LSB +: 3] == ibc_pkg::MBIAS_SUPPLY);
      vref_sel_ff <= bias_reference_config_ff[ibc_pkg::VREF_LSB +: 2];
      vref_valid_ff <= (bias_reference_config_ff[ibc_pkg::VREF_LSB +: 2] == ibc_pkg::VREF_2V75) ||
                       (bias_reference_config_ff[ibc_pkg::VREF_LSB +: 2] == ibc_pkg::VREF_2V50) ||
                       (bias_reference_config_ff[ibc_pkg::VREF_LSB +: 2] == ibc_pkg::VREF_1V375);
    end
  end

  // Channel-one enable: only the PDM code turns the channel on.
  always_ff @(posedge clk) begin
    if (rst) begin
      chan_en_ff <= 1'b0;
    end else if (ce) begin
      chan_en_ff <= (chan_one_source_config_ff[ibc_pkg::SRC_LSB +: 2] == ibc_pkg::SRC_PDM);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Volume code to gain mapping.
  ibc_vol_map u_vol (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .vol_code(chan_one_volume_ff),
    .vol_mute(chan_one_mute),
    .vol_half_db(chan_one_gain_half_db)
  );

  // Output assignments from registers.
  assign irq_pin_out = irq_pin_ff;
  assign mic_bias_from_vref = bias_vref_ff;
  assign mic_bias_from_supply = bias_supply_ff;
  assign vref_select = vref_sel_ff;
  assign vref_valid = vref_valid_ff;
  assign chan_one_enable = chan_en_ff;
  assign chan_one_gain_trim_code = chan_one_gain_trim_ff[ibc_pkg::TRIM_LSB +: 4];

endmodule : ibc_regs_top

`default_nettype wire

// File: rtl/ibc_pkg.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Shared constants for the interrupt, bias and channel-one register bank.
package ibc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register addresses on page zero.
  localparam logic [7:0] ADDR_PAGE = 8'h00;
  localparam logic [7:0] ADDR_INT_CFG = 8'h32;
  localparam logic [7:0] ADDR_EVENT_MASK = 8'h33;
  localparam logic [7:0] ADDR_LATCHED = 8'h36;
  localparam logic [7:0] ADDR_BIAS = 8'h3b;
  localparam logic [7:0] ADDR_CH1_SRC = 8'h3c;
  localparam logic [7:0] ADDR_CH1_VOL = 8'h3e;
  localparam logic [7:0] ADDR_CH1_TRIM = 8'h3f;

  // The only page that holds this bank.
  localparam logic [7:0] PAGE_ZERO = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic [7:0] RST_INT_CFG = 8'h00;
  localparam logic [7:0] RST_EVENT_MASK = 8'hff;
  localparam logic [1:0] RST_LATCHED = 2'h0;
  localparam logic [7:0] RST_BIAS = 8'h00;
  localparam logic [7:0] RST_CH1_SRC = 8'h00;
  localparam logic [7:0] RST_CH1_VOL = 8'hc9;
  localparam logic [7:0] RST_CH1_TRIM = 8'h80;

  ////////////////////////////////////////////////////////////////////////////////
  // Writable bit masks; bits outside a mask are read-only zero.
  localparam logic [7:0] WMASK_ALL = 8'hff;
  localparam logic [7:0] WMASK_INT_CFG = 8'he4;
  localparam logic [7:0] WMASK_BIAS = 8'h73;
  localparam logic [7:0] WMASK_CH1_SRC = 8'hfd;
  localparam logic [7:0] WMASK_CH1_TRIM = 8'hf0;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int BIT_CLK_ERR = 7;
  localparam int BIT_PLL_LOCK = 6;
  localparam int BIT_IRQ_POL = 7;
  localparam int INT_EVT_LSB = 5;
  localparam int BIT_LTCH_FILTER = 2;
  localparam int MBIAS_LSB = 4;
  localparam int VREF_LSB = 0;
  localparam int SRC_LSB = 5;
  localparam int TRIM_LSB = 4;
  localparam int LATCHED_PAD = 6;

  ////////////////////////////////////////////////////////////////////////////////
  // Field codes.
  localparam logic [1:0] INT_EVT_LEVEL = 2'h0;
  localparam logic [2:0] MBIAS_VREF = 3'h0;
  localparam logic [2:0] MBIAS_SUPPLY = 3'h6;
  localparam logic [1:0] VREF_2V75 = 2'h0;
  localparam logic [1:0] VREF_2V50 = 2'h1;
  localparam logic [1:0] VREF_1V375 = 2'h2;
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_PDM = 2'h2;
  localparam logic [7:0] VOL_MUTE = 8'h00;
  localparam logic [8:0] VOL_UNITY = 9'h0c9;

  // Serial target framing.
  localparam int SPI_READ_BIT = 0;
  localparam logic [2:0] SPI_LAST_BIT = 3'h7;

  // States of the serial target.
  typedef enum logic [1:0] {
    SPI_ST_CMD = 2'b00,
    SPI_ST_WDATA = 2'b01,
    SPI_ST_RDATA = 2'b10
  } ibc_spi_state_t;

  // Merges a host write into a register, keeping read-only bits at zero.
  function automatic logic [7:0] ibc_masked_write(input logic [7:0] wdata, input logic [7:0] wmask);
    ibc_masked_write = wdata & wmask;
  endfunction : ibc_masked_write

endpackage : ibc_pkg

`default_nettype wire

// File: rtl/ibc_spi_target.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Serial control-port target: one command byte holding a seven-bit address
// and a read flag, then data bytes with the address stepping by one.
module ibc_spi_target (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso_out,
  output logic spi_miso_oe,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);

  // Two-stage synchronisers, plus a third sclk stage for edge detection.
  logic sclk_s1_ff, sclk_s2_ff, sclk_s3_ff;
  logic cs_n_s1_ff, cs_n_s2_ff;
  logic mosi_s1_ff, mosi_s2_ff;
  // Bit counter, receive shifter, transmit shifter and running address.
  logic [2:0] bit_cnt_ff;
  logic [7:0] rx_ff;
  logic [7:0] tx_ff;
  logic [7:0] addr_ff;
  ibc_pkg::ibc_spi_state_t state_ff;

  logic active, sclk_rise, sclk_fall, byte_done;
  logic [7:0] rx_byte;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage and the third sclk stage feed any logic.
  always_ff @(posedge clk) begin
    if (rst) begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_s3_ff <= 1'b0;
      cs_n_s1_ff <= 1'b1;
      cs_n_s2_ff <= 1'b1;
      mosi_s1_ff <= 1'b0;
      mosi_s2_ff <= 1'b0;
    end else if (ce) begin
      sclk_s1_ff <= spi_sclk;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_s3_ff <= sclk_s2_ff;
      cs_n_s1_ff <= spi_cs_n;
      cs_n_s2_ff <= cs_n_s1_ff;
      mosi_s1_ff <= spi_mosi;
      mosi_s2_ff <= mosi_s1_ff;
    end
  end

  // Edge and byte detection on the synchronised pins.
  assign active = ~cs_n_s2_ff;
  assign sclk_rise = active & sclk_s2_ff & ~sclk_s3_ff;
  assign sclk_fall = active & ~sclk_s2_ff & sclk_s3_ff;
  assign rx_byte = {rx_ff[6:0], mosi_s2_ff};
  assign byte_done = sclk_rise & (bit_cnt_ff == ibc_pkg::SPI_LAST_BIT);

  // Register strobes; the command byte itself names the first read address.
  assign reg_addr = (state_ff == ibc_pkg::SPI_ST_CMD) ? {1'b0, rx_byte[7:1]} : addr_ff;
  assign reg_wdata = rx_byte;
  assign reg_wr = ce & byte_done & (state_ff == ibc_pkg::SPI_ST_WDATA);
  assign reg_rd = ce & byte_done & ((state_ff == ibc_pkg::SPI_ST_RDATA) |
                  ((state_ff == ibc_pkg::SPI_ST_CMD) & rx_byte[ibc_pkg::SPI_READ_BIT]));

  ////////////////////////////////////////////////////////////////////////////////
  // Bit counter and receive shifter; deselect restarts the frame.
  always_ff @(posedge clk) begin
    if (rst) begin
      bit_cnt_ff <= 3'h0;
      rx_ff <= 8'h00;
    end else if (ce) begin
      if (!active) begin
        bit_cnt_ff <= 3'h0;
      end else if (sclk_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        rx_ff <= rx_byte;
      end
    end
  end

  // Frame sequencer and running address.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ibc_pkg::SPI_ST_CMD;
      addr_ff <= 8'h00;
    end else if (ce) begin
      if (!active) begin
        state_ff <= ibc_pkg::SPI_ST_CMD;
      end else if (byte_done) begin
        case (state_ff)
          ibc_pkg::SPI_ST_CMD: begin
            // A read fetches at once, so the next access is one address on.
            state_ff <= rx_byte[ibc_pkg::SPI_READ_BIT] ? ibc_pkg::SPI_ST_RDATA : ibc_pkg::SPI_ST_WDATA;
            addr_ff <= rx_byte[ibc_pkg::SPI_READ_BIT] ? {1'b0, rx_byte[7:1]} + 8'h01 : {1'b0, rx_byte[7:1]};
          end
          ibc_pkg::SPI_ST_WDATA, ibc_pkg::SPI_ST_RDATA: begin
            addr_ff <= addr_ff + 8'h01;
          end
          default: begin
            state_ff <= ibc_pkg::SPI_ST_CMD;
          end
        endcase
      end
    end
  end

  // Transmit shifter: loaded on a fetch, shifted on falling edges within a byte.
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_ff <= 8'h00;
    end else if (ce) begin
      if (reg_rd) begin
        tx_ff <= reg_rdata;
      end else if (sclk_fall && (bit_cnt_ff != 3'h0)) begin
        tx_ff <= {tx_ff[6:0], 1'b0};
      end
    end
  end

  // Data out drives only while selected.
  assign spi_miso_out = tx_ff[7];
  assign spi_miso_oe = active;

endmodule : ibc_spi_target

`default_nettype wire

// File: rtl/ibc_vol_map.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Maps a volume code to a mute flag and a signed gain in half-decibel steps.
module ibc_vol_map (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] vol_code,
  output logic vol_mute,
  output logic signed [8:0] vol_half_db
);

  // Registered outputs so the datapath sees stable values.
  logic mute_ff;
  logic signed [8:0] half_db_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Code zero mutes; otherwise each code is half a decibel above the last.
  always_ff @(posedge clk) begin
    if (rst) begin
      mute_ff <= 1'b0;
      half_db_ff <= 9'sh000;
    end else if (ce) begin
      mute_ff <= (vol_code == ibc_pkg::VOL_MUTE);
      half_db_ff <= $signed({1'b0, vol_code} - ibc_pkg::VOL_UNITY);
    end
  end

  assign vol_mute = mute_ff;
  assign vol_half_db = half_db_ff;

endmodule : ibc_vol_map

`default_nettype wire

// File: tb/ibc_regs_props.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Checks reset values of the decoded outputs and what may move them.
module ibc_regs_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic audio_clk_err_evt,
  input wire logic pll_lock_evt,
  input wire logic spi_miso_oe,
  input wire logic irq_pin_out,
  input wire logic mic_bias_from_vref,
  input wire logic mic_bias_from_supply,
  input wire logic [1:0] vref_select,
  input wire logic vref_valid,
  input wire logic chan_one_enable,
  input wire logic chan_one_mute,
  input wire logic signed [8:0] chan_one_gain_half_db
);
  timeunit 1ns;
  timeprecision 1ns;
  // One clock domain, so one clocking and one disable serve all.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_irq_reset_idle: assert property ($fell(rst) |-> irq_pin_out [*3])
    else $error("irq active right after reset");
  a_irq_change_cause: assert property ($changed(irq_pin_out) |-> $past(audio_clk_err_evt, 2) ||
    $past(pll_lock_evt, 2) || $past(spi_miso_oe) || $past(spi_miso_oe, 2) || $past(spi_miso_oe, 3))
    else $error("irq moved without event or access");
  a_bias_reset: assert property ($fell(rst) |-> mic_bias_from_vref && !mic_bias_from_supply)
    else $error("bias select wrong after reset");
  a_vref_valid_code: assert property (vref_valid == (vref_select != 2'h3))
    else $error("reference valid flag disagrees with code");
  a_mute_gain_tie: assert property (chan_one_mute == (chan_one_gain_half_db == -9'sd201))
    else $error("mute flag disagrees with gain");
  a_gain_range: assert property (chan_one_gain_half_db <= 9'sd54 && chan_one_gain_half_db >= -9'sd201)
    else $error("gain outside volume range");
  a_vol_reset_unity: assert property ($fell(rst) |-> chan_one_gain_half_db == 9'sh000 && !chan_one_mute)
    else $error("volume not unity after reset");
  a_src_reset_off: assert property ($fell(rst) |-> !chan_one_enable ##1 !chan_one_enable)
    else $error("channel enabled after reset");
  a_enable_by_write: assert property ($changed(chan_one_enable) |-> $past(spi_miso_oe) || $past(spi_miso_oe, 2))
    else $error("channel enable moved outside a frame");
endmodule : ibc_regs_props

bind ibc_regs_top ibc_regs_props props_u (.clk(clk), .rst(rst), .audio_clk_err_evt(audio_clk_err_evt),
  .pll_lock_evt(pll_lock_evt), .spi_miso_oe(spi_miso_oe), .irq_pin_out(irq_pin_out),
  .mic_bias_from_vref(mic_bias_from_vref), .mic_bias_from_supply(mic_bias_from_supply),
  .vref_select(vref_select), .vref_valid(vref_valid), .chan_one_enable(chan_one_enable),
  .chan_one_mute(chan_one_mute), .chan_one_gain_half_db(chan_one_gain_half_db));

`default_nettype wire

// File: tb/ibc_host_model.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Host controller: sends one command byte and one data byte per frame, mode 0.
module ibc_host_model (
  input wire logic clk,
  input wire logic spi_miso_out,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  timeunit 1ns;
  timeprecision 1ns;
  // Serial half period in system clocks, above the four-clock floor.
  localparam int HALF = 5;

  // The serial clock stands low and the select high between frames.
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // Shifts MSB first; read data is taken at the rising edge it is sampled on.
  task automatic xfer(input logic [7:0] addr, input logic rd, input logic [7:0] wd, output logic [7:0] rv);
    logic [15:0] sh;
    sh = {addr[6:0], rd, wd};
    rv = 8'h00;
    spi_cs_n <= 1'b0;
    repeat (HALF) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      spi_mosi <= sh[i];
      repeat (HALF) @(posedge clk);
      spi_sclk <= 1'b1;
      if (i < 8) rv[i] = spi_miso_out;
      repeat (HALF) @(posedge clk);
      spi_sclk <= 1'b0;
    end
    repeat (HALF) @(posedge clk);
    spi_cs_n <= 1'b1;
    // A released data line shows the inverse of its last bit.
    spi_mosi <= ~sh[0];
    repeat (HALF) @(posedge clk);
  endtask : xfer
endmodule : ibc_host_model

`default_nettype wire

// File: tb/test_irq_bias_channel_one_config_regs.sv
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Self-checking bench: register table walk, then reset and interrupt cases.
module test_irq_bias_channel_one_config_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, audio_clk_err_evt, pll_lock_evt, spi_sclk, spi_cs_n, spi_mosi, spi_miso_out, spi_miso_oe;
  logic irq_pin_out, mic_bias_from_vref, mic_bias_from_supply, vref_valid, chan_one_enable, chan_one_mute;
  logic [1:0] vref_select;
  logic signed [8:0] chan_one_gain_half_db;
  logic [3:0] chan_one_gain_trim_code;
  logic [7:0] rdat;
  wire [15:0] outs;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  // Rows: address, write data, readback, expected decoded outputs.
  localparam logic [39:0] ROWS [14] = '{40'h3b62626800, 40'h3bff733000, 40'h3b01019800, 40'h3cfffd9800,
    40'h3c40409c00, 40'h3e00009f37, 40'h3e01019d38, 40'h3effff9c36, 40'h3ecaca9c01, 40'h4055009c01,
    40'h36ff009c01, 40'h0001019c01, 40'h3e55009c01, 40'h0000009c01};
  // Reset values by address.
  localparam logic [15:0] RSTV [6] = '{16'h33ff, 16'h3600, 16'h3b00, 16'h3c00, 16'h3ec9, 16'h3f80};

  assign outs = {mic_bias_from_vref, mic_bias_from_supply, vref_select, vref_valid, chan_one_enable,
    chan_one_mute, chan_one_gain_half_db};

  ibc_regs_top dut_u (.clk(clk), .rst(rst), .ce(1'b1), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso_out(spi_miso_out), .spi_miso_oe(spi_miso_oe),
    .audio_clk_err_evt(audio_clk_err_evt), .pll_lock_evt(pll_lock_evt), .irq_pin_out(irq_pin_out),
    .mic_bias_from_vref(mic_bias_from_vref), .mic_bias_from_supply(mic_bias_from_supply),
    .vref_select(vref_select), .vref_valid(vref_valid), .chan_one_enable(chan_one_enable),
    .chan_one_mute(chan_one_mute), .chan_one_gain_half_db(chan_one_gain_half_db),
    .chan_one_gain_trim_code(chan_one_gain_trim_code));
  ibc_host_model host_u (.clk(clk), .spi_miso_out(spi_miso_out), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));

  // 50 ns clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // Cuts a hang short well above the expected run length.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_outs(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t outs=%h exp=%h", $time, got, exp);
    end
  endtask : chk_outs

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.xfer(a, 1'b0, d, rdat);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host_u.xfer(a, 1'b1, 8'h00, rdat);
    chk_byte(rdat, e);
  endtask : rd

  // One-cycle event pulse, then time for latch and pin to settle.
  task automatic pulse(input logic a, input logic p);
    audio_clk_err_evt <= a;
    pll_lock_evt <= p;
    @(posedge clk);
    audio_clk_err_evt <= 1'b0;
    pll_lock_evt <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse

  // Main sequence: table walk, mid-run reset, then interrupt handling.
  initial begin
    rst = 1'b1;
    audio_clk_err_evt = 1'b0;
    pll_lock_evt = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int r = 0; r < 14; r++) begin
      wr(ROWS[r][39:32], ROWS[r][31:24]);
      rd(ROWS[r][39:32], ROWS[r][23:16]);
      chk_outs(outs, ROWS[r][15:0]);
    end
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk_outs(outs, 16'h8800);
    chk_byte({4'h0, chan_one_gain_trim_code}, 8'h08);
    for (int r = 0; r < 6; r++) rd(RSTV[r][15:8], RSTV[r][7:0]);
    pulse(1'b1, 1'b0);
    chk_byte({7'h00, irq_pin_out}, 8'h01);
    rd(8'h36, 8'h80);
    rd(8'h36, 8'h00);
    wr(8'h33, 8'h7f);
    pulse(1'b1, 1'b1);
    chk_byte({7'h00, irq_pin_out}, 8'h00);
    rd(8'h36, 8'hc0);
    chk_byte({7'h00, irq_pin_out}, 8'h01);
    wr(8'h32, 8'h04);
    pulse(1'b0, 1'b1);
    chk_byte({7'h00, irq_pin_out}, 8'h01);
    rd(8'h36, 8'h00);
    wr(8'h33, 8'hbf);
    chk_byte({7'h00, irq_pin_out}, 8'h00);
    rd(8'h36, 8'h40);
    wr(8'h32, 8'h80);
    chk_byte({7'h00, irq_pin_out}, 8'h00);
    pll_lock_evt <= 1'b1;
    @(posedge clk);
    rd(8'h36, 8'h40);
    chk_byte({7'h00, irq_pin_out}, 8'h01);
    pll_lock_evt <= 1'b0;
    rd(8'h36, 8'h40);
    rd(8'h36, 8'h00);
    conclude();
  end
endmodule : test_irq_bias_channel_one_config_regs

`default_nettype wire
